// file: hdl/pmic_regs_params.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef PMIC_REGS_PARAMS_SVH
`define PMIC_REGS_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_OUTPUT3_DELAY   8'h43
`define OFS_FORCED_SHUTDOWN 8'h91
`define OFS_REG1_SLEEP      8'h92
`define OFS_REG2_SLEEP      8'h93
`define OFS_REG4_VOLTAGE    8'h94

// ****************************************
// field positions
// ****************************************
`define CODE_MSB            7
`define CODE_LSB            1
`define LOW_BIT             0
`define DELAY_MSB           2

// ****************************************
// reset values
// ****************************************
`define RST_OUTPUT3_DELAY   3'h7
`define RST_REG1_SLEEP      8'h42
`define RST_REG2_SLEEP      8'he8
`define RST_REG4_VOLTAGE    8'hc0

// ****************************************
// timing
// ****************************************
`define CLK_HZ              10000000
`define TICK_US             500
`define TICK_CYCLES         (`TICK_US * (`CLK_HZ / 1000000))
`define DLY0_US             2500
`define DLY1_US             5000
`define DLY2_US             10000
`define DLY3_US             15000
`define DLY4_US             20000
`define DLY5_US             50000
`define DLY6_US             75000
`define DLY7_US             100000

`endif

// file: hdl/pmic_regs_pkg.sv
// types shared by the power-management register slice
package pmic_regs_pkg;

	// factory use of the third output pin
	typedef enum logic [1:0] {
		OUT3_DELAYED_PG = 2'b00,
		OUT3_SYSTEM_PG  = 2'b01,
		OUT3_LEVEL_SHIFT = 2'b10,
		OUT3_HOST_GPO   = 2'b11
	} out3_mode_t;

	// factory sleep-entry source of a regulator
	typedef enum logic [1:0] {
		SLEEP_SRC_NONE  = 2'b00,
		SLEEP_SRC_PIN1  = 2'b01,
		SLEEP_SRC_PIN2  = 2'b10
	} sleep_src_t;

	typedef enum logic [1:0] {
		PG_WAIT  = 2'b00,
		PG_COUNT = 2'b01,
		PG_GOOD  = 2'b10
	} pg_state_t;

	typedef enum logic {
		RAMP_TRACK = 1'b0,
		RAMP_SLEW  = 1'b1
	} ramp_state_t;

	// register write request, one cycle
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_t;

	// regulator target: code plus its step range
	typedef struct packed {
		logic [6:0] code;
		logic       range_25mv;
	} target_t;

endpackage

// file: hdl/pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// pins and clean levels
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	genvar b;
	generate
		for (b = 0; b < W; b++) begin : g_bit
			// a change counts once stages two and three agree
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					stage1[b]  <= 1'b0;
					stage2[b]  <= 1'b0;
					stage3[b]  <= 1'b0;
					o_level[b] <= 1'b0;
				end else begin
					stage1[b] <= i_pin[b];
					stage2[b] <= stage1[b];
					stage3[b] <= stage2[b];
					if (stage2[b] == stage3[b])
						o_level[b] <= stage3[b];
				end
			end
		end
	endgenerate

endmodule

// file: hdl/tick_divider.sv
// divider giving a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/100ps
module tick_divider #(
	parameter int CYCLES = 5000
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// enable pulse
	output logic      o_tick
);

	logic [15:0] count;

	// restart on reset only; a delay may begin at any point of the count
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count  <= 16'h0;
			o_tick <= 1'b0;
		end else if (count == 16'(CYCLES - 1)) begin
			count  <= 16'h0;
			o_tick <= 1'b1;
		end else begin
			count  <= count + 16'h1;
			o_tick <= 1'b0;
		end
	end

endmodule

// file: hdl/pmic_pg_sleep_vid_regs.sv
// power-good delay, forced shutdown, sleep and voltage code registers
`timescale 1ns/100ps
`include "pmic_regs_params.svh"

// Behaviour
// [RQ1] power-good delay starts once all grouped rails are in range
// [RQ2] delay codes 0..7 give 2.5, 5, 10, 15, 20, 50, 75, 100 ms
// [RQ3] delay field ignored unless pin is in delayed power-good mode
// [RQ4] writing 1 to shutdown bit shuts the device down at once
// [RQ5] shutdown resets the whole block and every register; the pin synchroniser here is reset by power-on only
// [RQ6] shutdown bit clears itself; writing 0 does nothing
// [RQ7] shutdown register resets to zero; only bit 0 writable
// [RQ8] regulator 1 sleep code in bits 7:1, same coding as normal
// [RQ9] regulator 1 sleep enable in bit 0, needs a sleep pin assigned
// [RQ10] regulator 2 sleep code in bits 7:1, same coding as normal
// [RQ11] regulator 2 sleep enable in bit 0, needs a sleep pin assigned
// [RQ12] regulator 4 normal voltage code in bits 7:1
// [RQ13] codes read in 10 mV or 25 mV steps by configured range
// [RQ14] on reduction, bit 0 low slews actively, high decays passively
// [RQ15] sleep code is target while enabled and its pin requests sleep
// [RQ16] reserved bits read zero and ignore writes
module pmic_pg_sleep_vid_regs
	import pmic_regs_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// register access port
	input  wire reg_wr_t    i_reg_wr,
	input  wire logic       i_rd_en,
	input  wire logic [7:0] i_rd_addr,
	output logic      [7:0] o_rd_data,
	output logic            o_rd_valid,
	// factory configuration, static; host level of the third output
	input  wire out3_mode_t i_output3_mode,
	input  wire sleep_src_t i_regulator1_sleep_src,
	input  wire sleep_src_t i_regulator2_sleep_src,
	input  wire logic [2:0] i_range_25mv,
	input  wire logic       i_output3_host_level,
	// pins from outside the clock domain
	input  wire logic       i_first_sleep_entry_pin,
	input  wire logic       i_second_sleep_entry_pin,
	input  wire logic       i_output3_rails_in_range,
	input  wire logic       i_system_rails_in_range,
	input  wire logic       i_level_shift_in,
	// regulator controls
	output target_t         o_regulator1_target,
	output target_t         o_regulator2_target,
	output target_t         o_regulator4_target,
	output logic            o_regulator4_active_slew,
	output logic            o_regulator4_passive_decay,
	// third output pin and shutdown
	output logic            o_third_general_output_pin,
	output logic            o_forced_shutdown
);

	// ****************************************
	// synchronised pins and tick
	// ****************************************
	logic [4:0] pins_raw;
	logic [4:0] pins;
	logic       tick;
	logic       dev_rst;

	assign pins_raw = {i_level_shift_in, i_system_rails_in_range,
		i_output3_rails_in_range, i_second_sleep_entry_pin,
		i_first_sleep_entry_pin};

	pin_sync #(
		.W(5)
	) u_sync (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_pin  (pins_raw),
		.o_level(pins)
	);

	wire sleep_pin1    = pins[0];
	wire sleep_pin2    = pins[1];
	wire out3_rails_ok = pins[2];
	wire sys_rails_ok  = pins[3];
	wire level_in      = pins[4];

	tick_divider #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.i_clk (i_clk),
		.i_rst (dev_rst),
		.o_tick(tick)
	);

	// ****************************************
	// registers
	// ****************************************
	logic [2:0] output3_power_good_delay;
	logic       forced_shutdown_control;
	logic [7:0] regulator1_sleep_control;
	logic [7:0] regulator2_sleep_control;
	logic [7:0] regulator4_voltage_select;

	// address decode of the write request
	wire wr_delay = i_reg_wr.en &&
		(i_reg_wr.addr == `OFS_OUTPUT3_DELAY);
	wire wr_shut  = i_reg_wr.en &&
		(i_reg_wr.addr == `OFS_FORCED_SHUTDOWN);
	wire wr_reg1  = i_reg_wr.en &&
		(i_reg_wr.addr == `OFS_REG1_SLEEP);
	wire wr_reg2  = i_reg_wr.en &&
		(i_reg_wr.addr == `OFS_REG2_SLEEP);
	wire wr_reg4  = i_reg_wr.en &&
		(i_reg_wr.addr == `OFS_REG4_VOLTAGE);
	wire shut_set = wr_shut && i_reg_wr.data[`LOW_BIT]; // RQ4

	// reset of all but the pin synchroniser and shutdown bit: power-on or forced shutdown
	assign dev_rst = i_rst | forced_shutdown_control; // RQ5

	// shutdown bit lives one cycle, then clears unless another write of one arrives
	always_ff @(posedge i_clk) begin
		if (i_rst)
			forced_shutdown_control <= 1'b0; // RQ7
		else if (shut_set)
			forced_shutdown_control <= 1'b1; // RQ4
		else
			forced_shutdown_control <= 1'b0; // RQ6
	end

	assign o_forced_shutdown = forced_shutdown_control;

	// only the three delay bits are stored; the rest stay zero
	always_ff @(posedge i_clk) begin
		if (dev_rst)
			output3_power_good_delay <= `RST_OUTPUT3_DELAY; // RQ5
		else if (wr_delay)
			output3_power_good_delay <=
				i_reg_wr.data[`DELAY_MSB:0]; // RQ16
	end

	// sleep control and voltage registers
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			regulator1_sleep_control  <= `RST_REG1_SLEEP; // RQ5
			regulator2_sleep_control  <= `RST_REG2_SLEEP;
			regulator4_voltage_select <= `RST_REG4_VOLTAGE;
		end else begin
			if (wr_reg1)
				regulator1_sleep_control <= i_reg_wr.data; // RQ8
			if (wr_reg2)
				regulator2_sleep_control <= i_reg_wr.data; // RQ10
			if (wr_reg4)
				regulator4_voltage_select <= i_reg_wr.data; // RQ12
		end
	end

	// ****************************************
	// read path
	// ****************************************
	logic [7:0] rd_mux;

	// unmapped offsets and reserved bits read as zero
	assign rd_mux =
		(i_rd_addr == `OFS_OUTPUT3_DELAY)   ?
			{5'h0, output3_power_good_delay} : // RQ16
		(i_rd_addr == `OFS_FORCED_SHUTDOWN) ?
			{7'h0, forced_shutdown_control} :  // RQ7
		(i_rd_addr == `OFS_REG1_SLEEP)      ? regulator1_sleep_control :
		(i_rd_addr == `OFS_REG2_SLEEP)      ? regulator2_sleep_control :
		(i_rd_addr == `OFS_REG4_VOLTAGE)    ? regulator4_voltage_select :
		8'h00;

	// read data holds until the next read
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			o_rd_data  <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_en;
			if (i_rd_en)
				o_rd_data <= rd_mux;
		end
	end

	// ****************************************
	// sleep target selection
	// ****************************************
	wire reg1_sleep_en = regulator1_sleep_control[`LOW_BIT];
	wire reg2_sleep_en = regulator2_sleep_control[`LOW_BIT];

	// enable counts only when a sleep pin is assigned in the factory
	wire reg1_pin_req =
		(i_regulator1_sleep_src == SLEEP_SRC_PIN1) ? sleep_pin1 :
		(i_regulator1_sleep_src == SLEEP_SRC_PIN2) ? sleep_pin2 :
		1'b0; // RQ9
	wire reg2_pin_req =
		(i_regulator2_sleep_src == SLEEP_SRC_PIN1) ? sleep_pin1 :
		(i_regulator2_sleep_src == SLEEP_SRC_PIN2) ? sleep_pin2 :
		1'b0; // RQ11

	wire reg1_asleep = reg1_sleep_en & reg1_pin_req; // RQ9
	wire reg2_asleep = reg2_sleep_en & reg2_pin_req; // RQ11

	// normal codes for 1 and 2 live outside; zero stands in here
	logic [6:0] reg1_normal_code;
	logic [6:0] reg2_normal_code;
	logic [6:0] reg1_code;
	logic [6:0] reg2_code;
	logic [6:0] reg4_code;

	assign reg1_normal_code = 7'h00;
	assign reg2_normal_code = 7'h00;
	assign reg1_code = reg1_asleep ?
		regulator1_sleep_control[`CODE_MSB:`CODE_LSB] :
		reg1_normal_code; // RQ15
	assign reg2_code = reg2_asleep ?
		regulator2_sleep_control[`CODE_MSB:`CODE_LSB] :
		reg2_normal_code; // RQ15
	assign reg4_code = regulator4_voltage_select[`CODE_MSB:`CODE_LSB];

	// targets carry the step range so the code is read correctly;
	// while awake the stand-in normal code is shown
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			o_regulator1_target <= '0;
			o_regulator2_target <= '0;
		end else begin
			o_regulator1_target <= {reg1_code, i_range_25mv[0]}; // RQ13
			o_regulator2_target <= {reg2_code, i_range_25mv[1]}; // RQ13
		end
	end

	// ****************************************
	// regulator 4 down-ramp
	// ****************************************
	ramp_state_t ramp_state;
	ramp_state_t next_ramp_state;
	logic [6:0]  applied4;
	logic [6:0]  next_applied4;

	wire decay_sel = regulator4_voltage_select[`LOW_BIT];

	// active slew walks one code per tick; decay jumps at once
	always_comb begin
		next_ramp_state = ramp_state;
		next_applied4   = applied4;
		unique case (ramp_state)
			RAMP_TRACK: begin
				if (reg4_code < applied4 && !decay_sel)
					next_ramp_state = RAMP_SLEW; // RQ14
				else
					next_applied4 = reg4_code; // RQ14
			end
			RAMP_SLEW: begin
				if (reg4_code >= applied4 || decay_sel) begin
					next_applied4   = reg4_code;
					next_ramp_state = RAMP_TRACK;
				end else if (tick) begin
					next_applied4 = applied4 - 7'h1; // RQ14
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			ramp_state <= RAMP_TRACK;
			applied4   <= 7'(`RST_REG4_VOLTAGE >> `CODE_LSB);
		end else begin
			ramp_state <= next_ramp_state;
			applied4   <= next_applied4;
		end
	end

	// outputs of the ramp, all from flip-flops
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			o_regulator4_target        <= '0;
			o_regulator4_active_slew   <= 1'b0;
			o_regulator4_passive_decay <= 1'b0;
		end else begin
			o_regulator4_target <= {next_applied4,
				i_range_25mv[2]}; // RQ13
			o_regulator4_active_slew <=
				(next_ramp_state == RAMP_SLEW); // RQ14
			o_regulator4_passive_decay <= decay_sel; // RQ14
		end
	end

	// ****************************************
	// power-good delay on the third output
	// ****************************************
	pg_state_t  pg_state;
	pg_state_t  next_pg_state;
	logic [7:0] pg_ticks;
	logic [7:0] next_pg_ticks;
	logic [7:0] delay_ticks;

	// delay code to ticks of the divider
	function automatic logic [7:0] ticks_of(input logic [2:0] sel);
		logic [7:0] t;
		t = 8'h0;
		unique case (sel)
			3'h0: t = 8'(`DLY0_US / `TICK_US); // RQ2
			3'h1: t = 8'(`DLY1_US / `TICK_US);
			3'h2: t = 8'(`DLY2_US / `TICK_US);
			3'h3: t = 8'(`DLY3_US / `TICK_US);
			3'h4: t = 8'(`DLY4_US / `TICK_US);
			3'h5: t = 8'(`DLY5_US / `TICK_US);
			3'h6: t = 8'(`DLY6_US / `TICK_US);
			3'h7: t = 8'(`DLY7_US / `TICK_US);
		endcase
		return t;
	endfunction

	assign delay_ticks = ticks_of(output3_power_good_delay);

	// counting starts when all grouped rails are in range and
	// restarts whenever one drops out; the first tick may come
	// early, so the delay is short by under one tick at most
	always_comb begin
		next_pg_state = pg_state;
		next_pg_ticks = pg_ticks;
		unique case (pg_state)
			PG_WAIT: begin
				next_pg_ticks = 8'h0;
				if (out3_rails_ok)
					next_pg_state = PG_COUNT; // RQ1
			end
			PG_COUNT: begin
				if (!out3_rails_ok) begin
					next_pg_state = PG_WAIT;
				end else if (pg_ticks >= delay_ticks) begin
					next_pg_state = PG_GOOD; // RQ1
				end else if (tick) begin
					next_pg_ticks = pg_ticks + 8'h1;
				end
			end
			PG_GOOD: begin
				if (!out3_rails_ok)
					next_pg_state = PG_WAIT;
			end
			default: begin
				next_pg_state = PG_WAIT;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			pg_state <= PG_WAIT;
			pg_ticks <= 8'h0;
		end else begin
			pg_state <= next_pg_state;
			pg_ticks <= next_pg_ticks;
		end
	end

	// pin function; the delay only matters in delayed mode
	logic out3_level;

	assign out3_level =
		(i_output3_mode == OUT3_DELAYED_PG) ?
			(pg_state == PG_GOOD) :                     // RQ1
		(i_output3_mode == OUT3_SYSTEM_PG)  ? sys_rails_ok : // RQ3
		(i_output3_mode == OUT3_LEVEL_SHIFT) ? level_in :    // RQ3
		i_output3_host_level;                                // RQ3

	always_ff @(posedge i_clk) begin
		if (dev_rst)
			o_third_general_output_pin <= 1'b0;
		else
			o_third_general_output_pin <= out3_level;
	end

endmodule

// file: tb/pmic_pg_sleep_vid_regs_assertions.sv
// checker for the power-good, shutdown and voltage code register slice
`timescale 1ns/100ps
module pmic_regs_chk
	import pmic_regs_pkg::*;
#(
	parameter int TICK_CYCLES = 5000
) (
	// clock and reset
	input wire logic       i_clk,
	input wire logic       i_rst,
	// register access port
	input wire reg_wr_t    i_reg_wr,
	input wire logic [7:0] i_rd_addr,
	input wire logic [7:0] o_rd_data,
	input wire logic       o_rd_valid,
	// pin inputs and outputs
	input wire out3_mode_t i_output3_mode,
	input wire logic       i_output3_host_level,
	input wire logic       i_output3_rails_in_range,
	input wire target_t    o_regulator4_target,
	input wire logic       o_regulator4_active_slew,
	input wire logic       o_regulator4_passive_decay,
	input wire logic       o_third_general_output_pin,
	input wire logic       o_forced_shutdown
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic        sd_set;
	logic        vid_wr;
	logic [2:0]  dly_code;
	logic [31:0] rails_cnt;

	// decoded host requests seen at the register port
	assign sd_set = i_reg_wr.en && i_reg_wr.addr == 8'h91 &&
		i_reg_wr.data[0];
	assign vid_wr = i_reg_wr.en && i_reg_wr.addr == 8'h94;

	// delay code the register should hold, tracked from host writes
	always_ff @(posedge i_clk) begin
		if (i_rst || o_forced_shutdown)
			dly_code <= 3'h7;
		else if (i_reg_wr.en && i_reg_wr.addr == 8'h43)
			dly_code <= i_reg_wr.data[2:0];
	end

	// cycles since the raw grouped rails came into range
	always_ff @(posedge i_clk) begin
		if (!i_output3_rails_in_range)
			rails_cnt <= 32'h0;
		else if (rails_cnt != 32'hffffffff)
			rails_cnt <= rails_cnt + 32'h1;
	end

	// delay of each code in half-millisecond ticks
	function automatic int ticks_for(input logic [2:0] c);
		int t;
		t = 0;
		case (c)
			3'h0: t = 5;
			3'h1: t = 10;
			3'h2: t = 20;
			3'h3: t = 30;
			3'h4: t = 40;
			3'h5: t = 100;
			3'h6: t = 150;
			3'h7: t = 200;
		endcase
		return t;
	endfunction

	a_shutdown_on_write: assert property (
		sd_set |-> ##[1:2] o_forced_shutdown)
		else $error("shutdown pulse missing after write of one");
	a_shutdown_has_cause: assert property (
		o_forced_shutdown |-> $past(sd_set) || $past(sd_set, 2))
		else $error("shutdown pulse without a write of one");
	a_shutdown_self_clear: assert property (
		o_forced_shutdown |=> !o_forced_shutdown)
		else $error("shutdown pulse longer than one cycle");
	a_shutdown_resets_all: assert property (
		o_forced_shutdown |=> ##1
		(o_regulator4_target.code == 7'h60 &&
		!o_regulator4_passive_decay))
		else $error("registers not back at reset after shutdown");
	a_delay_reserved_zero: assert property (
		o_rd_valid && $past(i_rd_addr) == 8'h43 |->
		o_rd_data[7:3] == 5'h00)
		else $error("reserved delay bits read nonzero");
	a_shutdown_bits_zero: assert property (
		o_rd_valid && $past(i_rd_addr) == 8'h91 |->
		o_rd_data[7:1] == 7'h00)
		else $error("read-only shutdown bits read nonzero");
	a_decay_bit_copy: assert property (
		vid_wr |-> ##2
		o_regulator4_passive_decay == $past(i_reg_wr.data[0], 2))
		else $error("decay select does not follow written bit");
	a_host_level_follow: assert property (
		i_output3_mode == OUT3_HOST_GPO && !o_forced_shutdown |=>
		o_third_general_output_pin == $past(i_output3_host_level))
		else $error("pin does not follow host level");
	a_good_after_rails: assert property (
		i_output3_mode == OUT3_DELAYED_PG &&
		$rose(o_third_general_output_pin) |->
		$past(i_output3_rails_in_range, 8))
		else $error("power good raised too soon after rails");
	a_good_delay_window: assert property (
		i_output3_mode == OUT3_DELAYED_PG &&
		$rose(o_third_general_output_pin) |->
		rails_cnt >= 32'((ticks_for(dly_code) - 1) * TICK_CYCLES) &&
		rails_cnt <= 32'(ticks_for(dly_code) * TICK_CYCLES + 8))
		else $error("power good outside the delay window");

	// main scenarios reached
	c_shutdown: cover property (o_forced_shutdown);
	c_good: cover property ($rose(o_third_general_output_pin));
	c_slew_done: cover property (o_regulator4_active_slew ##1
		!o_regulator4_active_slew);
endmodule

bind pmic_pg_sleep_vid_regs pmic_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
	.i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
	.i_output3_mode(i_output3_mode),
	.i_output3_host_level(i_output3_host_level),
	.i_output3_rails_in_range(i_output3_rails_in_range),
	.o_regulator4_target(o_regulator4_target),
	.o_regulator4_active_slew(o_regulator4_active_slew),
	.o_regulator4_passive_decay(o_regulator4_passive_decay),
	.o_third_general_output_pin(o_third_general_output_pin),
	.o_forced_shutdown(o_forced_shutdown));

// file: tb/pmic_regs_host.sv
// host model issuing register writes and reads on the falling edge
`timescale 1ns/100ps
module pmic_regs_host
	import pmic_regs_pkg::*;
(
	// clock
	input  wire logic       i_clk,
	// register access toward the block
	output reg_wr_t         o_reg_wr,
	output logic            o_rd_en,
	output logic [7:0]      o_rd_addr,
	input  wire logic [7:0] i_rd_data,
	input  wire logic       i_rd_valid
);
	initial begin
		o_reg_wr = '0;
		o_rd_en = 1'b0;
		o_rd_addr = 8'h00;
	end

	// idle lines are inverted so stale values never look valid
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_reg_wr = '{en: 1'b1, addr: a, data: d};
		@(negedge i_clk);
		o_reg_wr = '{en: 1'b0, addr: ~a, data: ~d};
	endtask

	// answer is due half a cycle after the taking edge
	task automatic read(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(negedge i_clk);
		o_rd_en = 1'b1;
		o_rd_addr = a;
		@(negedge i_clk);
		o_rd_en = 1'b0;
		o_rd_addr = ~a;
		ok = i_rd_valid;
		d = i_rd_data;
	endtask
endmodule

// file: tb/test_pmic_pg_sleep_vid_regs.sv
// self-checking bench for the power-good, shutdown and voltage registers
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module test_pmic_pg_sleep_vid_regs;
	import pmic_regs_pkg::*;
	localparam int TC = 4;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	reg_wr_t wr;
	logic rd_en, rd_valid, ok, slew, decay, pin, sdn;
	logic [7:0] rd_addr, rd_data, d;
	out3_mode_t mode = OUT3_DELAYED_PG;
	logic host_lvl = 1'b0;
	logic slp1 = 1'b0;
	logic slp2 = 1'b0;
	logic rails = 1'b0;
	logic sys_ok = 1'b0;
	logic lvl_in = 1'b0;
	sleep_src_t src1 = SLEEP_SRC_PIN1;
	target_t t1, t2, t4;
	int err_count = 0;
	int compares = 0;
	int n;
	int dly[8] = '{5, 10, 20, 30, 40, 100, 150, 200};

	always #50 i_clk = ~i_clk;

	pmic_regs_host HOST (.i_clk(i_clk), .o_reg_wr(wr), .o_rd_en(rd_en),
		.o_rd_addr(rd_addr), .i_rd_data(rd_data), .i_rd_valid(rd_valid));

	// range: regulators 1 and 4 in 25 mV steps, regulator 2 in 10 mV
	pmic_pg_sleep_vid_regs #(.TICK_CYCLES(TC)) DUT (
		.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr), .i_rd_en(rd_en),
		.i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.i_output3_mode(mode), .i_regulator1_sleep_src(src1),
		.i_regulator2_sleep_src(SLEEP_SRC_PIN2), .i_range_25mv(3'h5),
		.i_output3_host_level(host_lvl), .i_first_sleep_entry_pin(slp1),
		.i_second_sleep_entry_pin(slp2), .i_output3_rails_in_range(rails),
		.i_system_rails_in_range(sys_ok), .i_level_shift_in(lvl_in),
		.o_regulator1_target(t1), .o_regulator2_target(t2),
		.o_regulator4_target(t4), .o_regulator4_active_slew(slew),
		.o_regulator4_passive_decay(decay),
		.o_third_general_output_pin(pin), .o_forced_shutdown(sdn));

	// *********************************
	// tasks
	// *********************************
	task end_of_test;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// a missing read answer ends the run at once
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		HOST.read(a, d, ok);
		if (ok !== 1'b1) begin
			err_count++;
			end_of_test();
		end
		`CHK(d, e)
	endtask

	task automatic wait_pin(input int lim);
		n = 0;
		while (pin !== 1'b1) begin
			@(negedge i_clk);
			n++;
			if (n > lim) begin
				err_count++;
				end_of_test();
			end
		end
	endtask

	// *********************************
	// main sequence
	// *********************************
	initial begin
		repeat (5) @(negedge i_clk);
		i_rst = 1'b0;
		chk_rd(8'h43, 8'h07);
		chk_rd(8'h91, 8'h00);
		chk_rd(8'h92, 8'h42);
		chk_rd(8'h93, 8'he8);
		chk_rd(8'h94, 8'hc0);
		chk_rd(8'h50, 8'h00);
		HOST.write(8'h43, 8'hf8);
		HOST.write(8'h91, 8'hfe);
		chk_rd(8'h43, 8'h00);
		chk_rd(8'h91, 8'h00);
		// sleep codes take over only while enabled and requested
		HOST.write(8'h92, 8'h2b);
		chk_rd(8'h92, 8'h2b);
		slp1 = 1'b1;
		repeat (8) @(negedge i_clk);
		`CHK(t1, {7'h15, 1'b1})
		// no sleep pin assigned: the enable bit has no effect
		src1 = SLEEP_SRC_NONE;
		repeat (3) @(negedge i_clk);
		`CHK(t1.code, 7'h00)
		src1 = SLEEP_SRC_PIN1;
		HOST.write(8'h93, 8'h14);
		slp2 = 1'b1;
		repeat (8) @(negedge i_clk);
		`CHK(t2.code, 7'h00)
		HOST.write(8'h93, 8'h15);
		repeat (3) @(negedge i_clk);
		`CHK(t2, {7'h0a, 1'b0})
		slp1 = 1'b0;
		repeat (8) @(negedge i_clk);
		`CHK(t1.code, 7'h00)
		// passive decay jumps, active slew walks one code per tick
		HOST.write(8'h94, 8'hbf);
		repeat (3) @(negedge i_clk);
		`CHK({t4, decay}, {7'h5f, 1'b1, 1'b1})
		HOST.write(8'h94, 8'hb8);
		repeat (3) @(negedge i_clk);
		`CHK(slew, 1'b1)
		repeat (6 * TC) @(negedge i_clk);
		`CHK({t4, slew, decay}, {7'h5c, 1'b1, 2'b00})
		// every delay code, counted from rails in range
		for (int c = 0; c < 8; c++) begin
			HOST.write(8'h43, 8'(c));
			rails = 1'b1;
			wait_pin(dly[c] * TC + 12);
			`CHK(n >= dly[c] * TC - TC, 1'b1)
			rails = 1'b0;
			repeat (8) @(negedge i_clk);
			`CHK(pin, 1'b0)
		end
		// forced shutdown pulses once and restores reset values
		HOST.write(8'h91, 8'h01);
		n = 0;
		while (sdn !== 1'b1 && n < 3) begin
			@(negedge i_clk);
			n++;
		end
		`CHK(sdn, 1'b1)
		@(negedge i_clk);
		`CHK(sdn, 1'b0)
		chk_rd(8'h94, 8'hc0);
		chk_rd(8'h92, 8'h42);
		chk_rd(8'h91, 8'h00);
		// host output mode ignores the delay field
		mode = OUT3_HOST_GPO;
		i_rst = 1'b1;
		@(negedge i_clk);
		i_rst = 1'b0;
		rails = 1'b1;
		host_lvl = 1'b1;
		repeat (2) @(negedge i_clk);
		`CHK(pin, 1'b1)
		host_lvl = 1'b0;
		repeat (2) @(negedge i_clk);
		`CHK(pin, 1'b0)
		// system and level-shift functions follow their own inputs
		mode = OUT3_SYSTEM_PG;
		sys_ok = 1'b1;
		repeat (8) @(negedge i_clk);
		`CHK(pin, 1'b1)
		mode = OUT3_LEVEL_SHIFT;
		repeat (8) @(negedge i_clk);
		`CHK(pin, 1'b0)
		lvl_in = 1'b1;
		repeat (8) @(negedge i_clk);
		`CHK(pin, 1'b1)
		end_of_test();
	end
endmodule
